/* File: common/frc_params.svh */
// Register map, field positions, reset values and timing counts of the flash rewrite control.
`ifndef FRC_PARAMS_SVH
`define FRC_PARAMS_SVH
`define FRC_IDX_MODE 12'hFFE
`define FRC_IDX_USER_EW 12'hFE2
`define FRC_IDX_BLK_EW 12'hFE0
`define FRC_IDX_CMD 12'hFE4
`define FRC_IDX_ADDR 12'hFE5
`define FRC_IDX_DATA 12'hFE6
`define FRC_IDX_STATUS 12'hFE7
`define FRC_POS_MODE 1
`define FRC_POS_USER_EW 4
`define FRC_POS_BLK_EW 2
`define FRC_ST_READY 7
`define FRC_ST_ERASE_ERR 5
`define FRC_ST_PROG_ERR 4
`define FRC_ARRAY_LO 16'h1000
`define FRC_ARRAY_HI 16'hFFFF
`define FRC_BOOT_LO 16'hF000
`define FRC_BLK8_LO 16'h1000
`define FRC_BLK8_HI 16'h2FFF
`define FRC_VEC_LO 16'hFFFC
`define FRC_VEC_HI 16'hFFFD
`define FRC_ERASED 8'hFF
`define FRC_ERASE_LAST 12'hFFF
`define FRC_PROG_CYCLES 4'hF
`define FRC_WORD_ZERO 32'h0000_0000
`define FRC_STATUS_RESET 8'h80
`define FRC_TX_IDLE 1'b1
`endif

/* File: common/frc_pkg.sv */
// Types shared by the flash rewrite control.
package frc_pkg;
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_PROG = 2'b01,
    SEQ_ERASE = 2'b10
  } frc_seq_type;
  typedef enum logic [7:0] {
    CMD_READ_ARRAY = 8'hFF,
    CMD_READ_STATUS = 8'h70,
    CMD_CLEAR_STATUS = 8'h50,
    CMD_PROGRAM = 8'h40,
    CMD_BLOCK_ERASE = 8'h20
  } frc_cmd_type;
endpackage

/* File: rtl/frc_flash_rewrite_control.sv */
// Flash rewrite control: protected mode bits, command sequencer, flash array and boot strap capture.
//
// Behaviour
// RULE1 - 60 Kbyte flash array, rewritable by CPU.
// RULE2 - Rewritable range is 01000 to 0FFFF.
// RULE3 - Array unreadable while rewrite mode active.
// RULE4 - Exactly five commands accepted in rewrite mode.
// RULE5 - Boot needs boot and transmit pins high.
// RULE6 - Software keeps system clock below 4 MHz.
// RULE7 - Mode select bit needs 0 then 1.
// RULE8 - All-user erase enable needs 0 then 1.
// RULE9 - 8 KB block enable gates that block.
// RULE10 - Software exit: read array, clear bits.
// RULE11 - Software masks interrupts before rewrite mode.
// RULE12 - Watchdog held cleared during program or erase.
// RULE13 - Software feeds running watchdog during rewrite.
// RULE14 - Any reset returns all control state.
// RULE15 - No valid interrupt service in rewrite mode.
// RULE16 - Software keeps enables low when idle.
// RULE17 - Serial link returns transmit data and busy; code holds serialTransmitData at idle 1.
// RULE18 - Interrupted operation may leave erroneous contents.
// RULE19 - Boot start address from FFFC and FFFD.
// RULE20 - Write of 1 without prior 0 ignored.
`include "frc_params.svh"

module frc_flash_rewrite_control (
  input wire logic clk,
  input wire logic rst,
  input wire logic [13:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic boot_mode_select_pin,
  input wire logic serial_transmit_boot_pin,
  output logic serialTransmitData,
  output logic serialReadyBusy,
  output logic rewriteMode,
  output logic watchdogClear,
  output logic interruptServiceBlocked,
  output logic bootMode,
  output logic [15:0] bootStartAddress
);

  // ****************************************
  // Bus slave
  // ****************************************
  logic waitReq_r;
  logic [31:0] readData_r;
  logic [31:0] readData_nxt;
  logic ack;
  logic wrAck;
  logic [11:0] regIdx;
  logic aligned;
  assign ack = (avs_read | avs_write) & ~waitReq_r;
  assign wrAck = ack & avs_write & avs_byteenable[0] & aligned;
  assign regIdx = avs_address[13:2];
  assign aligned = (avs_address[1:0] == 2'h0);
  // The answer comes one cycle after the request is seen, so read data is settled at the sampling edge.
  always_ff @(posedge clk) begin
    if (rst) begin
      waitReq_r <= 1'b1;
    end else if (ack) begin
      waitReq_r <= 1'b1;
    end else if (avs_read | avs_write) begin
      waitReq_r <= 1'b0;
    end
  end

  // ****************************************
  // Flash array and protected bits
  // ****************************************
  logic [7:0] flashMem [`FRC_ARRAY_LO:`FRC_ARRAY_HI]; // see RULE1
  logic [2:0] protBit_r;
  logic [2:0] armed_r;
  logic [15:0] flashAddr_r;
  logic [7:0] flashData_r;
  logic [7:0] status_r;
  logic readStatus_r;
  frc_pkg::frc_seq_type seq_r;
  logic [3:0] progCnt_r;
  logic [11:0] eraseIdx_r;
  logic [15:0] opAddr_r;
  assign rewriteMode = protBit_r[0];
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_prot
      localparam logic [11:0] IDX = (gi == 0) ? `FRC_IDX_MODE : (gi == 1) ? `FRC_IDX_USER_EW : `FRC_IDX_BLK_EW;
      localparam int POS = (gi == 0) ? `FRC_POS_MODE : (gi == 1) ? `FRC_POS_USER_EW : `FRC_POS_BLK_EW;
      logic hit;
      assign hit = wrAck & (regIdx == IDX);
      always_ff @(posedge clk) begin
        if (rst) begin
          protBit_r[gi] <= 1'b0; // see RULE14
          armed_r[gi] <= 1'b0;
        end else if (hit) begin
          if (!avs_writedata[POS]) begin
            protBit_r[gi] <= 1'b0;
            armed_r[gi] <= 1'b1;
          end else begin
            protBit_r[gi] <= protBit_r[gi] | armed_r[gi]; // see RULE7 see RULE8 see RULE9 see RULE20
            armed_r[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Command sequencer
  // ****************************************
  logic cmdWrite;
  logic [7:0] cmdByte;
  logic inRange;
  logic inBlk8;
  logic mayWrite;
  assign cmdWrite = wrAck & (regIdx == `FRC_IDX_CMD) & rewriteMode & (seq_r == frc_pkg::SEQ_IDLE);
  assign cmdByte = avs_writedata[7:0];
  assign inRange = (flashAddr_r >= `FRC_ARRAY_LO); // see RULE2
  assign inBlk8 = (flashAddr_r >= `FRC_BLK8_LO) && (flashAddr_r <= `FRC_BLK8_HI);
  assign mayWrite = inRange & protBit_r[1] & (~inBlk8 | protBit_r[2]); // see RULE8 see RULE9
  always_ff @(posedge clk) begin
    if (rst) begin
      flashAddr_r <= `FRC_ARRAY_LO;
      flashData_r <= `FRC_ERASED;
    end else if (wrAck && regIdx == `FRC_IDX_ADDR) begin
      flashAddr_r[7:0] <= avs_writedata[7:0];
      if (avs_byteenable[1]) begin
        flashAddr_r[15:8] <= avs_writedata[15:8];
      end
    end else if (wrAck && regIdx == `FRC_IDX_DATA) begin
      flashData_r <= avs_writedata[7:0];
    end
  end

  // Only the five known commands act; any other byte is dropped without effect.
  always_ff @(posedge clk) begin
    if (rst) begin
      seq_r <= frc_pkg::SEQ_IDLE; // see RULE14 see RULE18
      status_r <= `FRC_STATUS_RESET;
      readStatus_r <= 1'b0;
      progCnt_r <= 4'h0;
      eraseIdx_r <= 12'h000;
      opAddr_r <= `FRC_ARRAY_LO;
    end else begin
      case (seq_r)
        frc_pkg::SEQ_IDLE: begin
          if (cmdWrite) begin
            case (cmdByte) // see RULE4
              frc_pkg::CMD_READ_ARRAY: readStatus_r <= 1'b0;
              frc_pkg::CMD_READ_STATUS: readStatus_r <= 1'b1;
              frc_pkg::CMD_CLEAR_STATUS: begin
                status_r[`FRC_ST_ERASE_ERR] <= 1'b0;
                status_r[`FRC_ST_PROG_ERR] <= 1'b0;
              end
              frc_pkg::CMD_PROGRAM: begin
                readStatus_r <= 1'b1;
                if (mayWrite) begin
                  seq_r <= frc_pkg::SEQ_PROG;
                  status_r[`FRC_ST_READY] <= 1'b0;
                  progCnt_r <= `FRC_PROG_CYCLES;
                  opAddr_r <= flashAddr_r;
                end else begin
                  status_r[`FRC_ST_PROG_ERR] <= 1'b1;
                end
              end
              frc_pkg::CMD_BLOCK_ERASE: begin
                readStatus_r <= 1'b1;
                if (mayWrite) begin
                  seq_r <= frc_pkg::SEQ_ERASE;
                  status_r[`FRC_ST_READY] <= 1'b0;
                  eraseIdx_r <= 12'h000;
                  opAddr_r <= {flashAddr_r[15:12], 12'h000};
                end else begin
                  status_r[`FRC_ST_ERASE_ERR] <= 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
        frc_pkg::SEQ_PROG: begin
          if (progCnt_r == 4'h0) begin
            seq_r <= frc_pkg::SEQ_IDLE;
            status_r[`FRC_ST_READY] <= 1'b1;
          end else begin
            progCnt_r <= progCnt_r - 4'h1;
          end
        end
        frc_pkg::SEQ_ERASE: begin
          if (eraseIdx_r == `FRC_ERASE_LAST) begin
            seq_r <= frc_pkg::SEQ_IDLE;
            status_r[`FRC_ST_READY] <= 1'b1;
          end else begin
            eraseIdx_r <= eraseIdx_r + 12'h001;
          end
        end
        default: begin
          seq_r <= frc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end
  // The array has no reset, so an erase cut short by reset leaves a half-erased block.
  always_ff @(posedge clk) begin
    if (!rst && seq_r == frc_pkg::SEQ_PROG && progCnt_r == 4'h0) begin
      flashMem[opAddr_r] <= flashMem[opAddr_r] & flashData_r;
    end else if (!rst && seq_r == frc_pkg::SEQ_ERASE) begin
      flashMem[{opAddr_r[15:12], eraseIdx_r}] <= `FRC_ERASED; // see RULE18
    end
  end

  // ****************************************
  // Read data and outputs
  // ****************************************
  always_comb begin
    readData_nxt = `FRC_WORD_ZERO;
    if (aligned) begin
      case (regIdx)
        `FRC_IDX_MODE: readData_nxt[`FRC_POS_MODE] = protBit_r[0];
        `FRC_IDX_USER_EW: readData_nxt[`FRC_POS_USER_EW] = protBit_r[1];
        `FRC_IDX_BLK_EW: readData_nxt[`FRC_POS_BLK_EW] = protBit_r[2];
        `FRC_IDX_ADDR: readData_nxt[15:0] = flashAddr_r;
        `FRC_IDX_STATUS: readData_nxt[7:0] = status_r;
        `FRC_IDX_DATA: begin
          if (rewriteMode) begin
            readData_nxt[7:0] = readStatus_r ? status_r : 8'h00; // see RULE3
          end else if (inRange) begin
            readData_nxt[7:0] = flashMem[flashAddr_r];
          end
        end
        default: readData_nxt = `FRC_WORD_ZERO;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      readData_r <= `FRC_WORD_ZERO;
    end else if (waitReq_r && avs_read) begin
      readData_r <= readData_nxt;
    end
  end
  logic busy_r;
  logic blocked_r;
  logic txLine_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      busy_r <= 1'b0;
      blocked_r <= 1'b0;
      txLine_r <= `FRC_TX_IDLE;
    end else begin
      busy_r <= (seq_r != frc_pkg::SEQ_IDLE); // see RULE12
      blocked_r <= rewriteMode; // see RULE15
      txLine_r <= `FRC_TX_IDLE;
    end
  end
  assign avs_waitrequest = waitReq_r;
  assign avs_readdata = readData_r;
  assign watchdogClear = busy_r;
  assign serialReadyBusy = busy_r; // see RULE17
  assign serialTransmitData = txLine_r;
  assign interruptServiceBlocked = blocked_r;

  // ****************************************
  // Boot strap capture
  // ****************************************
  logic [2:0] bootSync_r;
  logic [2:0] txdSync_r;
  logic bootF_r;
  logic txdF_r;
  logic strapDone_r;
  logic bootMode_r;
  logic [15:0] bootStart_r;
  // Pins settle through three flops; a change counts once the last two agree.
  always_ff @(posedge clk) begin
    bootSync_r <= {bootSync_r[1:0], boot_mode_select_pin};
    txdSync_r <= {txdSync_r[1:0], serial_transmit_boot_pin};
    if (bootSync_r[1] == bootSync_r[2]) begin
      bootF_r <= bootSync_r[2];
    end
    if (txdSync_r[1] == txdSync_r[2]) begin
      txdF_r <= txdSync_r[2];
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      strapDone_r <= 1'b0;
      bootMode_r <= 1'b0;
      bootStart_r <= 16'h0000;
    end else if (!strapDone_r) begin
      strapDone_r <= 1'b1;
      bootMode_r <= bootF_r & txdF_r; // see RULE5
      if (bootF_r) begin
        bootStart_r <= {flashMem[`FRC_VEC_HI], flashMem[`FRC_VEC_LO]}; // see RULE19
      end
    end
  end
  assign bootMode = bootMode_r;
  assign bootStartAddress = bootStart_r;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mode_needs_zero_a: assert property ($rose(protBit_r[0]) |-> $past(armed_r[0])) // see RULE7
    else $error("Mode bit set without prior zero write.");
  user_ew_zero_a: assert property ($rose(protBit_r[1]) |-> $past(armed_r[1])) // see RULE8
    else $error("User enable set without prior zero write.");
  blk_ew_zero_a: assert property ($rose(protBit_r[2]) |-> $past(armed_r[2])) // see RULE9
    else $error("Block enable set without prior zero write.");
  lone_one_a: assert property (wrAck && regIdx == `FRC_IDX_MODE && avs_writedata[`FRC_POS_MODE] && !armed_r[0]
    |=> $stable(protBit_r[0])) // see RULE20
    else $error("Lone one write changed mode bit.");
  array_hidden_a: assert property (ack && avs_read && rewriteMode && regIdx == `FRC_IDX_DATA && !readStatus_r
    |-> avs_readdata == `FRC_WORD_ZERO) // see RULE3
    else $error("Array data visible in rewrite mode.");
  wdt_clear_a: assert property (seq_r != frc_pkg::SEQ_IDLE |=> watchdogClear) // see RULE12
    else $error("Watchdog not cleared during operation.");
  range_guard_a: assert property (seq_r == frc_pkg::SEQ_IDLE ##1 seq_r != frc_pkg::SEQ_IDLE
    |-> $past(inRange && protBit_r[1])) // see RULE2
    else $error("Operation started outside range or without enable.");
  prog_length_a: assert property ($rose(seq_r == frc_pkg::SEQ_PROG) |-> (seq_r == frc_pkg::SEQ_PROG) [*8]) // see RULE4
    else $error("Program ended too early.");
  irq_block_a: assert property (rewriteMode |=> interruptServiceBlocked) // see RULE15
    else $error("Interrupt service not blocked in rewrite mode.");
  reset_clear_a: assert property (disable iff (1'b0) rst |=> !rewriteMode && !protBit_r[1]) // see RULE14
    else $error("Reset left control bits set.");

  enter_cov: cover property ($rose(rewriteMode));
  prog_cov: cover property (seq_r == frc_pkg::SEQ_PROG ##1 seq_r == frc_pkg::SEQ_IDLE);
  erase_cov: cover property ($rose(seq_r == frc_pkg::SEQ_ERASE));
  boot_cov: cover property ($rose(bootMode));

endmodule // frc_flash_rewrite_control

/* File: tb/frc_cpu_model.sv */
// Bus master model of the on-chip CPU that issues flash commands.
`include "frc_params.svh"
module frc_cpu_model (
  input wire logic clk,
  output logic [13:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ns;
  int timeouts = 0;
  logic intMask = 1'b0;
  logic [1:0] clockDivRatio = 2'b00;
  int watchdogFeeds = 0;
  initial begin
    avs_address = 14'h0000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
  end
  // ****************************************
  // Bus access
  // ****************************************
  // The request stands until waitrequest is sampled low, or for at most 64 cycles, after which a timeout is counted.
  task automatic access(input logic wr, input logic [11:0] idx, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 64);
    q = avs_readdata;
    if (n >= 64) timeouts++;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, idx, d, q);
  endtask
  task automatic rd(input logic [11:0] idx, output logic [31:0] q);
    access(1'b0, idx, 32'h0000_0000, q);
  endtask
  // A protected bit only sets when the last write to it before the write of 1 was a write of 0.
  task automatic set_prot(input logic [11:0] idx, input logic [31:0] d);
    wr(idx, 32'h0000_0000);
    wr(idx, d);
  endtask
  task automatic feed_watchdog();
    watchdogFeeds++;
  endtask
  task automatic enter_rewrite();
    clockDivRatio = 2'b11;
    intMask = 1'b1;
    set_prot(`FRC_IDX_MODE, 32'h0000_0002);
  endtask
  task automatic leave_rewrite();
    wr(`FRC_IDX_CMD, 32'h0000_00FF);
    wr(`FRC_IDX_USER_EW, 32'h0000_0000);
    wr(`FRC_IDX_BLK_EW, 32'h0000_0000);
    wr(`FRC_IDX_MODE, 32'h0000_0000);
    intMask = 1'b0;
  endtask
endmodule // frc_cpu_model

/* File: tb/tb_top.sv */
// Self-checking bench of the flash rewrite control.
`include "frc_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; \
  $display("[ERR] t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bootPin = 1'b0;
  logic txPin = 1'b0;
  logic [13:0] address;
  logic rdEn, wrEn;
  logic [31:0] wdata, rdata, q;
  logic [3:0] be;
  logic waitReq, txData, readyBusy, rewriteMode, wdClear, intBlocked, bootMode;
  logic [15:0] bootAddr;
  int num_errors = 0;
  int checks = 0;
  initial forever #50 clk = ~clk;
  frc_flash_rewrite_control i_dut (.clk(clk), .rst(rst), .avs_address(address), .avs_read(rdEn),
    .avs_write(wrEn), .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .boot_mode_select_pin(bootPin), .serial_transmit_boot_pin(txPin),
    .serialTransmitData(txData), .serialReadyBusy(readyBusy), .rewriteMode(rewriteMode),
    .watchdogClear(wdClear), .interruptServiceBlocked(intBlocked), .bootMode(bootMode),
    .bootStartAddress(bootAddr));
  frc_cpu_model i_cpu (.clk(clk), .avs_address(address), .avs_read(rdEn), .avs_write(wrEn),
    .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(waitReq));
  // A bus wait that runs out ends the run at once as a failure.
  always @(posedge clk) begin
    if (i_cpu.timeouts != 0) begin
      close_out();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic close_out();
    num_errors += i_cpu.timeouts;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Four edges of reset rather than three, since the strap synchroniser is not reset.
  task automatic do_reset(input logic b, input logic t);
    @(posedge clk);
    bootPin <= b;
    txPin <= t;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic poll_ready();
    int n;
    n = 0;
    do begin
      i_cpu.rd(`FRC_IDX_STATUS, q);
      i_cpu.feed_watchdog();
      n++;
    end while (q[7] !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic flash_cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] c);
    i_cpu.wr(`FRC_IDX_ADDR, {16'h0000, a});
    i_cpu.wr(`FRC_IDX_DATA, {24'h000000, d});
    i_cpu.wr(`FRC_IDX_CMD, {24'h000000, c});
  endtask
  task automatic chk_status(input logic [7:0] e);
    i_cpu.rd(`FRC_IDX_STATUS, q);
    `CHK(q[7:0], e)
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    do_reset(1'b0, 1'b0);
    `CHK({rewriteMode, bootMode, waitReq, txData}, 4'h3)
    i_cpu.rd(12'h001, q);
    `CHK(q, 32'h0000_0000)
    i_cpu.wr(`FRC_IDX_MODE, 32'h0000_0002);
    @(negedge clk);
    `CHK(rewriteMode, 1'b0)
    i_cpu.enter_rewrite();
    @(negedge clk);
    @(negedge clk);
    `CHK({rewriteMode, intBlocked}, 2'h3)
    i_cpu.rd(`FRC_IDX_DATA, q);
    `CHK(q, 32'h0000_0000)
    i_cpu.wr(`FRC_IDX_USER_EW, 32'h0000_0010);
    flash_cmd(16'hF000, 8'h00, frc_pkg::CMD_PROGRAM);
    poll_ready();
    chk_status(8'h90);
    i_cpu.wr(`FRC_IDX_CMD, 32'h0000_0010);
    chk_status(8'h90);
    i_cpu.wr(`FRC_IDX_CMD, {24'h000000, frc_pkg::CMD_CLEAR_STATUS});
    chk_status(8'h80);
    i_cpu.set_prot(`FRC_IDX_USER_EW, 32'h0000_0010);
    flash_cmd(16'hF000, 8'h00, frc_pkg::CMD_BLOCK_ERASE);
    @(negedge clk);
    @(negedge clk);
    `CHK({wdClear, readyBusy}, 2'h3)
    poll_ready();
    chk_status(8'h80);
    flash_cmd(16'hFFFC, 8'h34, frc_pkg::CMD_PROGRAM);
    poll_ready();
    flash_cmd(16'hFFFD, 8'h12, frc_pkg::CMD_PROGRAM);
    poll_ready();
    chk_status(8'h80);
    `CHK(wdClear, 1'b0)
    flash_cmd(16'h1000, 8'h00, frc_pkg::CMD_PROGRAM);
    poll_ready();
    chk_status(8'h90);
    i_cpu.wr(`FRC_IDX_CMD, {24'h000000, frc_pkg::CMD_CLEAR_STATUS});
    i_cpu.set_prot(`FRC_IDX_BLK_EW, 32'h0000_0004);
    flash_cmd(16'h2FFF, 8'hFF, frc_pkg::CMD_PROGRAM);
    poll_ready();
    chk_status(8'h80);
    i_cpu.leave_rewrite();
    i_cpu.wr(`FRC_IDX_ADDR, 32'h0000_FFFC);
    i_cpu.rd(`FRC_IDX_DATA, q);
    `CHK(q[7:0], 8'h34)
    `CHK({rewriteMode, intBlocked}, 2'h0)
    i_cpu.wr(`FRC_IDX_ADDR, 32'h0000_0800);
    i_cpu.rd(`FRC_IDX_DATA, q);
    `CHK(q, 32'h0000_0000)
    i_cpu.enter_rewrite();
    i_cpu.set_prot(`FRC_IDX_USER_EW, 32'h0000_0010);
    do_reset(1'b1, 1'b1);
    `CHK({rewriteMode, bootMode}, 2'h1)
    `CHK(bootAddr, 16'h1234)
    i_cpu.enter_rewrite();
    flash_cmd(16'hF000, 8'h00, frc_pkg::CMD_PROGRAM);
    poll_ready();
    chk_status(8'h90);
    do_reset(1'b1, 1'b0);
    `CHK(bootMode, 1'b0)
    close_out();
  end
endmodule // tb_top
